// ===== bench/flash_model.sv
// Behavioural flash macro answering the engine's command port
`timescale 1ns/1ps
module flash_model
	import flash_call_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Command from the engine
	input wire logic fl_req,
	input wire flash_op_e fl_op,
	input wire logic [1:0] fl_macro,
	input wire logic [13:0] fl_addr,
	// Answer to the engine
	output logic fl_ack,
	output logic [7:0] fl_rdata
);
	logic [3:0] wait_cnt; // Cycles spent on the current command
	logic slow; // Alternates prompt and slow answers
	flash_op_e log_q[$]; // Every command taken, in order

	// User byte content, chosen so a checksum carries often
	function automatic logic [7:0] user_byte(input logic [13:0] a);
		return a[7:0] + 8'h11 + {2'b00, a[13:8]};
	endfunction

	// One 64-byte row seen as eight tables of eight
	function automatic logic [7:0] table_byte(input logic [5:0] i);
		return 8'hA0 + {2'b00, i};
	endfunction

	// Acknowledge after two or five request cycles; read data only in the ack cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fl_ack <= 1'b0;
			fl_rdata <= 8'h00;
			wait_cnt <= 4'h0;
			slow <= 1'b0;
			log_q.delete();
		end else if (fl_ack) begin
			// Data is only promised in the ack cycle, so spoil it afterwards
			fl_ack <= 1'b0;
			fl_rdata <= ~fl_rdata;
		end else if (fl_req) begin
			if (wait_cnt == (slow ? 4'h4 : 4'h1)) begin
				fl_ack <= 1'b1;
				wait_cnt <= 4'h0;
				slow <= ~slow;
				log_q.push_back(fl_op);
				fl_rdata <= (fl_op == FL_TABLE_READ) ? table_byte(fl_addr[5:0]) :
					user_byte(fl_addr);
			end else begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end else begin
			// Idle bus shows a changing pattern, never a stale value
			fl_rdata <= ~fl_rdata;
		end
	end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the supervisory flash call engine
`timescale 1ns/1ps
`include "flash_call_cfg.svh"
module testbench
	import flash_call_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite; // APB master side
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_v, st;
	logic pready, pslverr, err_v;
	logic fl_req, fl_ack, fl_read_locked; // Flash side
	flash_op_e fl_op;
	logic [1:0] fl_macro;
	logic [13:0] fl_addr;
	logic [7:0] fl_pulse_div, fl_seq_delay, fl_rdata, exp_a, exp_x;
	logic [15:0] sum;
	logic [15:0] rev_id = `REVISION_ID; // Fixed revision word, split for A and X
	int n_errors, n_compared;
	flash_op_e ea_seq[5] = '{FL_ERASE_USER, FL_PROG_ZERO, FL_ERASE_USER, FL_ERASE_PROT,
		FL_PROG_PROT_ZERO};

	flash_call_engine dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fl_req(fl_req), .fl_op(fl_op), .fl_macro(fl_macro),
		.fl_addr(fl_addr), .fl_pulse_div(fl_pulse_div), .fl_seq_delay(fl_seq_delay),
		.fl_ack(fl_ack), .fl_rdata(fl_rdata), .fl_read_locked(fl_read_locked));
	flash_model model_u (.pclk(pclk), .presetn(presetn), .fl_req(fl_req), .fl_op(fl_op),
		.fl_macro(fl_macro), .fl_addr(fl_addr), .fl_ack(fl_ack), .fl_rdata(fl_rdata));

	// Free-running 25 MHz clock
	always #20 pclk = ~pclk;

	// Count and report one comparison
	task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; entered right after a rising edge, leaves one idle cycle
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// No wait count assumed; a slave that never answers is left to the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Read a register and compare it
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 8'h00);
		compare(rd_v, exp);
	endtask

	// Caller duties: keys, block, pulse divider, delay, op code, stack pointer
	task automatic setup(input logic [7:0] op, input logic [7:0] blk, input logic [7:0] key);
		apb(1'b1, 12'h000, key);
		apb(1'b1, 12'h004, 8'h43);
		apb(1'b1, 12'h008, blk);
		apb(1'b1, 12'h010, 8'h07);
		apb(1'b1, 12'h018, 8'h56);
		apb(1'b1, `REG_ACC, op);
		apb(1'b1, `REG_SP, 8'h40);
	endtask

	// Start a call and poll status until done or fail, bounded
	task automatic call();
		apb(1'b1, `REG_CALL, 8'h01);
		for (int k = 0; k < 3000; k++) begin
			apb(1'b0, `REG_STATUS, 8'h00);
			if (rd_v[2:1] != 2'b00) break;
		end
		st = rd_v;
		if (st[2:1] == 2'b00) n_errors++;
	endtask

	// Single place where the run ends
	task automatic print_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog: the sequence needs well under this many cycles
	initial begin
		#(40 * 60000);
		n_errors++;
		print_verdict();
	end

	// Main sequence
	initial begin
		{pclk, psel, penable, pwrite, fl_read_locked} = 5'b00000;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		presetn = 1'b0;
		n_errors = 0;
		n_compared = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(`REG_STATUS, 32'h0);
		apb(1'b0, 12'h040, 8'h00);
		compare(err_v, 1'b1);
		// Wrong key: refused, nothing touched
		model_u.log_q.delete();
		setup(`OP_CHECKSUM, 8'h01, 8'h3B);
		call();
		compare(st[2], 1'b1);
		compare(model_u.log_q.size(), 0);
		rd_chk(12'h000, 32'h3B);
		rd_chk(12'h004, 32'h43);
		// Every table, with junk in the upper block bits
		for (int t = 0; t < 8; t++) begin
			setup(`OP_TABLE_READ, 8'hA8 | t[7:0], 8'h3A);
			call();
			for (int i = 0; i < 8; i++)
				rd_chk(12'(i * 4), model_u.table_byte(6'(t * 8 + i)));
			exp_a = (t == 0) ? rev_id[7:0] : (t == 1) ? `INT_REV_COUNT : 8'hFF;
			exp_x = (t == 0) ? rev_id[15:8] : 8'hFF;
			rd_chk(`REG_ACC, {24'h0, exp_a});
			rd_chk(`REG_IDX, {24'h0, exp_x});
		end
		// Checksum over one and two blocks from block zero
		for (int n = 1; n < 3; n++) begin
			model_u.log_q.delete();
			setup(`OP_CHECKSUM, n[7:0], 8'h3A);
			call();
			sum = 16'h0000;
			for (int a = 0; a < n * 64; a++) sum = sum + {8'h00, model_u.user_byte(14'(a))};
			compare(model_u.log_q.size(), n * 64);
			rd_chk(12'h000, {24'h0, sum[7:0]});
			rd_chk(12'h004, {24'h0, sum[15:8]});
		end
		// Read-locked checksum reports the failure codes
		fl_read_locked <= 1'b1;
		setup(`OP_CHECKSUM, 8'h01, 8'h3A);
		call();
		fl_read_locked <= 1'b0;
		compare(st[2], 1'b1);
		rd_chk(`REG_ACC, 32'h0);
		rd_chk(12'h004, 32'h0);
		rd_chk(12'h000, 32'h1);
		// Erase-all: exact command order, nothing else issued
		model_u.log_q.delete();
		setup(`OP_ERASE_ALL, 8'h00, 8'h3A);
		call();
		compare(model_u.log_q.size(), 5);
		for (int i = 0; i < 5 && i < model_u.log_q.size(); i++)
			compare(32'(model_u.log_q[i]), 32'(ea_seq[i]));
		compare(fl_macro, `MACRO_BOTTOM);
		compare(fl_pulse_div, 8'h07);
		compare(fl_seq_delay, 8'h56);
		print_verdict();
	end
endmodule

// ===== hw/flash_call_cfg.svh
// Constants for the supervisory flash call engine
`ifndef FLASH_CALL_CFG_SVH
`define FLASH_CALL_CFG_SVH

// Key and return byte values
`define FLASH_KEY 8'h3A
`define SP_FRAME 8'h03
`define FAIL_KEY 8'h01
`define ALL_ONES 8'hFF
`define ZERO_BYTE 8'h00

// Operation codes placed in the accumulator
`define OP_ERASE_ALL 8'h05
`define OP_TABLE_READ 8'h06
`define OP_CHECKSUM 8'h07

// Register byte offsets
`define REG_ACC 12'h020
`define REG_IDX 12'h024
`define REG_SP 12'h028
`define REG_CALL 12'h02C
`define REG_STATUS 12'h030
`define PARAM_WORD_HI 7'h00

// Parameter block slots, F8h upward
`define PARAM_FIRST_KEY 3'h0
`define PARAM_SECOND_KEY 3'h1
`define PARAM_BLOCK 3'h2
`define PARAM_CLOCK 3'h4
`define PARAM_DELAY 3'h6
`define PARAM_LAST 3'h7

// Control and status bit positions
`define CALL_START_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_FAIL_BIT 2

// Flash geometry
`define MACRO_TOP 2'h0
`define MACRO_BOTTOM 2'h0
`define USER_STEP_LAST 2'h2
`define PROT_STEP_LAST 2'h1
`define ALL_BLOCKS 9'h100
`define BLOCK_BYTES_ZERO 6'h00

// Fixed identity values, arbitrary
`define REVISION_ID 16'h5A01
`define INT_REV_COUNT 8'h00

`endif

// ===== hw/flash_call_engine.sv
// Supervisory call engine: erase-all, table read and checksum over APB
`timescale 1ns/1ps
`include "flash_call_cfg.svh"
// Functional notes
// - Erase-all wipes user data and protection
// - Three hidden blocks above protection untouched
// - Top macro first: erase, zero, erase
// - Then protection: erase, zero, top first
// - Table row is eight tables of eight
// - Only low three block bits pick table
// - Table bytes overwrite parameter block F8h-FFh
// - Table 0: revision ID low byte in A, high byte in X
// - Table 1: revision counter A, X FFh
// - Tables 2-7: A and X FFh
// - Revision ID is fixed sixteen bits
// - Block count 1 means block 0, 0 all
// - Sum bytes, carry into high byte
// - Low sum to first key, high second
// - Protection failure returns 00h, 00h, 01h
module flash_call_engine
	import flash_call_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flash macro command port
	output logic fl_req,
	output flash_op_e fl_op,
	output logic [1:0] fl_macro,
	output logic [13:0] fl_addr,
	output logic [7:0] fl_pulse_div,
	output logic [7:0] fl_seq_delay,
	input wire logic fl_ack,
	input wire logic [7:0] fl_rdata,
	input wire logic fl_read_locked
);
	// Bus slave state
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [31:0] rd_mux; // Read data for the addressed register
	logic mapped; // Address hits a register
	logic wr_fire; // Write takes effect this edge

	// Engine state
	engine_state_e state_reg, state_next;
	logic [7:0] param_reg [0:7]; // Parameter block F8h-FFh
	logic [7:0] param_next [0:7];
	logic [7:0] acc_reg, acc_next; // Accumulator in and out
	logic [7:0] idx_reg, idx_next; // Index register out
	logic [7:0] sp_reg, sp_next; // Stack pointer at the call
	logic [7:0] op_reg, op_next; // Latched operation code
	logic [1:0] step_reg, step_next; // Sub-step inside a macro
	logic [1:0] macro_reg, macro_next; // Macro being worked on
	logic [13:0] addr_reg, addr_next; // Byte address or table byte
	logic wait_reg, wait_next; // Flash command outstanding
	logic done_reg, done_next;
	logic fail_reg, fail_next;
	logic [2:0] tbl_reg, tbl_next; // Table number taken at the call
	logic [15:0] rev_id; // Fixed revision word

	// Port and accumulator links
	logic port_start;
	flash_op_e port_op;
	logic [13:0] port_addr;
	logic port_done;
	logic [7:0] port_rdata;
	logic csum_clr, csum_add;
	logic [15:0] csum;
	logic key_ok; // Both keys match
	logic [8:0] blk_count; // Blocks to checksum
	logic [14:0] csum_end; // Bytes to checksum
	logic csum_last;

	// Keys and checksum span
	assign key_ok = (param_reg[`PARAM_FIRST_KEY] == `FLASH_KEY) &&
		(param_reg[`PARAM_SECOND_KEY] == sp_reg + `SP_FRAME);
	assign blk_count = (param_reg[`PARAM_BLOCK] == `ZERO_BYTE) ? `ALL_BLOCKS :
		{1'b0, param_reg[`PARAM_BLOCK]};
	assign csum_end = {blk_count, `BLOCK_BYTES_ZERO};
	assign csum_last = ({1'b0, addr_reg} + 15'h0001) == csum_end;
	// Table address uses the number latched at the call, since the table bytes
	// themselves overwrite the block parameter slot part way through the read
	assign port_addr = (state_reg == ST_TABLE) ?
		{8'h00, tbl_reg, addr_reg[2:0]} : addr_reg;
	assign rev_id = `REVISION_ID;

	// Register decode and read mux
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		if (paddr[11:5] == `PARAM_WORD_HI && paddr[1:0] == 2'h0) begin
			rd_mux = {24'h00_0000, param_reg[paddr[4:2]]};
		end else begin
			case (paddr)
				`REG_ACC: rd_mux = {24'h00_0000, acc_reg};
				`REG_IDX: rd_mux = {24'h00_0000, idx_reg};
				`REG_SP: rd_mux = {24'h00_0000, sp_reg};
				`REG_CALL: rd_mux = 32'h0000_0000;
				`REG_STATUS: begin
					rd_mux[`STAT_BUSY_BIT] = (state_reg != ST_IDLE);
					rd_mux[`STAT_DONE_BIT] = done_reg;
					rd_mux[`STAT_FAIL_BIT] = fail_reg;
				end
				default: mapped = 1'b0;
			endcase
		end
	end

	// APB answer: ready is registered from the setup cycle, so no wait states
	always_comb begin
		pready_next = psel && !penable;
		pslverr_next = psel && !penable && !mapped;
		prdata_next = prdata_reg;
		if (psel && !penable) begin
			prdata_next = (!pwrite && mapped) ? rd_mux : 32'h0000_0000;
		end
	end
	assign wr_fire = psel && penable && pready_reg && pwrite && !pslverr_reg;

	// Bus slave registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// Engine sequencer; software writes are accepted only while idle
	always_comb begin
		state_next = state_reg;
		param_next = param_reg;
		acc_next = acc_reg;
		idx_next = idx_reg;
		sp_next = sp_reg;
		op_next = op_reg;
		step_next = step_reg;
		macro_next = macro_reg;
		addr_next = addr_reg;
		wait_next = wait_reg;
		done_next = done_reg;
		fail_next = fail_reg;
		tbl_next = tbl_reg;
		port_start = 1'b0;
		port_op = FL_NONE;
		csum_clr = 1'b0;
		csum_add = 1'b0;
		if (wr_fire && state_reg == ST_IDLE) begin
			if (paddr[11:5] == `PARAM_WORD_HI) begin
				param_next[paddr[4:2]] = pwdata[7:0];
			end
			if (paddr == `REG_ACC) begin
				acc_next = pwdata[7:0];
			end
			if (paddr == `REG_SP) begin
				sp_next = pwdata[7:0];
			end
			if (paddr == `REG_CALL && pwdata[`CALL_START_BIT]) begin
				// The call latches the accumulator as operation code
				state_next = ST_CHECK;
				op_next = acc_reg;
				done_next = 1'b0;
				fail_next = 1'b0;
			end
		end
		case (state_reg)
			ST_IDLE: begin
				wait_next = 1'b0;
			end
			ST_CHECK: begin
				step_next = 2'h0;
				addr_next = 14'h0000;
				tbl_next = param_reg[`PARAM_BLOCK][2:0];
				if (!key_ok) begin
					// Bad key leaves flash and parameter block as they are
					fail_next = 1'b1;
					state_next = ST_FINISH;
				end else begin
					case (op_reg)
						`OP_ERASE_ALL: begin
							macro_next = `MACRO_TOP;
							state_next = ST_EA_USER;
						end
						`OP_TABLE_READ: begin
							state_next = ST_TABLE;
						end
						`OP_CHECKSUM: begin
							macro_next = `MACRO_BOTTOM;
							if (fl_read_locked) begin
								acc_next = `ZERO_BYTE;
								param_next[`PARAM_SECOND_KEY] = `ZERO_BYTE;
								param_next[`PARAM_FIRST_KEY] = `FAIL_KEY;
								fail_next = 1'b1;
								state_next = ST_FINISH;
							end else begin
								csum_clr = 1'b1;
								state_next = ST_CSUM;
							end
						end
						default: begin
							state_next = ST_FINISH;
						end
					endcase
				end
			end
			ST_EA_USER: begin
				// Erase, bulk zero, erase again on user space only
				port_op = (step_reg == 2'h1) ? FL_PROG_ZERO : FL_ERASE_USER;
				if (!wait_reg) begin
					port_start = 1'b1;
					wait_next = 1'b1;
				end else if (port_done) begin
					wait_next = 1'b0;
					if (step_reg == `USER_STEP_LAST) begin
						step_next = 2'h0;
						if (macro_reg == `MACRO_BOTTOM) begin
							macro_next = `MACRO_TOP;
							state_next = ST_EA_PROT;
						end else begin
							macro_next = macro_reg - 2'h1;
						end
					end else begin
						step_next = step_reg + 2'h1;
					end
				end
			end
			ST_EA_PROT: begin
				// Protection block only; hidden blocks get no command at all
				port_op = (step_reg == 2'h1) ? FL_PROG_PROT_ZERO : FL_ERASE_PROT;
				if (!wait_reg) begin
					port_start = 1'b1;
					wait_next = 1'b1;
				end else if (port_done) begin
					wait_next = 1'b0;
					if (step_reg == `PROT_STEP_LAST) begin
						step_next = 2'h0;
						if (macro_reg == `MACRO_BOTTOM) begin
							state_next = ST_FINISH;
						end else begin
							macro_next = macro_reg - 2'h1;
						end
					end else begin
						step_next = step_reg + 2'h1;
					end
				end
			end
			ST_TABLE: begin
				port_op = FL_TABLE_READ;
				if (!wait_reg) begin
					port_start = 1'b1;
					wait_next = 1'b1;
				end else if (port_done) begin
					wait_next = 1'b0;
					param_next[addr_reg[2:0]] = port_rdata;
					if (addr_reg[2:0] == `PARAM_LAST) begin
						state_next = ST_FINISH;
						case (tbl_reg)
							3'h0: begin
								acc_next = rev_id[7:0];
								idx_next = rev_id[15:8];
							end
							3'h1: begin
								acc_next = `INT_REV_COUNT;
								idx_next = `ALL_ONES;
							end
							default: begin
								acc_next = `ALL_ONES;
								idx_next = `ALL_ONES;
							end
						endcase
					end else begin
						addr_next = addr_reg + 14'h0001;
					end
				end
			end
			ST_CSUM: begin
				port_op = FL_READ;
				if (!wait_reg) begin
					port_start = 1'b1;
					wait_next = 1'b1;
				end else if (port_done) begin
					wait_next = 1'b0;
					csum_add = 1'b1;
					if (csum_last) begin
						state_next = ST_CSUM_END;
					end else begin
						addr_next = addr_reg + 14'h0001;
					end
				end
			end
			ST_CSUM_END: begin
				// Sum settles one cycle after the last add
				param_next[`PARAM_FIRST_KEY] = csum[7:0];
				param_next[`PARAM_SECOND_KEY] = csum[15:8];
				state_next = ST_FINISH;
			end
			ST_FINISH: begin
				done_next = 1'b1;
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Engine registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			for (int i = 0; i < 8; i++) begin
				param_reg[i] <= 8'h00;
			end
			acc_reg <= 8'h00;
			idx_reg <= 8'h00;
			sp_reg <= 8'h00;
			op_reg <= 8'h00;
			step_reg <= 2'h0;
			macro_reg <= 2'h0;
			addr_reg <= 14'h0000;
			wait_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			tbl_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			param_reg <= param_next;
			acc_reg <= acc_next;
			idx_reg <= idx_next;
			sp_reg <= sp_next;
			op_reg <= op_next;
			step_reg <= step_next;
			macro_reg <= macro_next;
			addr_reg <= addr_next;
			wait_reg <= wait_next;
			done_reg <= done_next;
			fail_reg <= fail_next;
			tbl_reg <= tbl_next;
		end
	end

	// Flash command port
	flash_cmd_port port_u (
		.pclk(pclk),
		.presetn(presetn),
		.start(port_start),
		.op(port_op),
		.macro(macro_reg),
		.addr(port_addr),
		.done(port_done),
		.rdata(port_rdata),
		.fl_req(fl_req),
		.fl_op(fl_op),
		.fl_macro(fl_macro),
		.fl_addr(fl_addr),
		.fl_ack(fl_ack),
		.fl_rdata(fl_rdata)
	);

	// Checksum accumulator
	sum16_acc sum_u (
		.pclk(pclk),
		.presetn(presetn),
		.clr(csum_clr),
		.add(csum_add),
		.data(port_rdata),
		.sum(csum)
	);

	// Outputs straight from flops
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign fl_pulse_div = param_reg[`PARAM_CLOCK];
	assign fl_seq_delay = param_reg[`PARAM_DELAY];

	// Checks
	sequence call_checked_s;
		state_reg == ST_CHECK && key_ok;
	endsequence
	sequence erase_call_s;
		call_checked_s ##0 op_reg == `OP_ERASE_ALL;
	endsequence

	bad_key_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_CHECK && !key_ok) |=> state_reg == ST_FINISH ##1
		(state_reg == ST_IDLE && fail_reg && !fl_req))
		else $error("bad key did not end the call cleanly");
	erase_top_first_a: assert property (@(posedge pclk) disable iff (!presetn)
		erase_call_s |=> (state_reg == ST_EA_USER && macro_reg == `MACRO_TOP) ##1 fl_req)
		else $error("erase-all did not start on the top macro");
	prot_after_user_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state_reg == ST_EA_PROT) |-> $past(state_reg) == ST_EA_USER &&
		$past(macro_reg) == `MACRO_BOTTOM && macro_reg == `MACRO_TOP)
		else $error("protection phase began out of order");
	hidden_untouched_a: assert property (@(posedge pclk) disable iff (!presetn)
		fl_req |-> (fl_op inside {FL_ERASE_USER, FL_PROG_ZERO, FL_ERASE_PROT,
		FL_PROG_PROT_ZERO, FL_READ, FL_TABLE_READ}) && (fl_op == FL_READ ||
		fl_op == FL_TABLE_READ || fl_addr == 14'h0000))
		else $error("flash command outside user or protection space");
	table_select_a: assert property (@(posedge pclk) disable iff (!presetn)
		(fl_req && fl_op == FL_TABLE_READ) |-> fl_addr[5:3] == tbl_reg
		&& fl_addr[13:6] == 8'h00)
		else $error("table address not from low block bits");
	table_return_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_TABLE && port_done && addr_reg[2:0] == `PARAM_LAST &&
		tbl_reg != 3'h0) |=> idx_reg == `ALL_ONES &&
		(tbl_reg != 3'h1 ? acc_reg == `ALL_ONES :
		acc_reg == `INT_REV_COUNT))
		else $error("table return registers wrong");
	csum_span_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_CSUM && port_done && csum_last) |->
		addr_reg[5:0] == 6'h3F && addr_reg[13:6] == param_reg[`PARAM_BLOCK] - 8'h01)
		else $error("checksum span wrong");
	csum_result_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_CSUM_END |=> param_reg[`PARAM_FIRST_KEY] == $past(csum[7:0]) &&
		param_reg[`PARAM_SECOND_KEY] == $past(csum[15:8]) ##1 done_reg)
		else $error("checksum not returned in keys");
	lock_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
		(call_checked_s ##0 (op_reg == `OP_CHECKSUM && fl_read_locked)) |=>
		acc_reg == `ZERO_BYTE && param_reg[`PARAM_SECOND_KEY] == `ZERO_BYTE &&
		param_reg[`PARAM_FIRST_KEY] == `FAIL_KEY && fail_reg)
		else $error("protection failure code wrong");
endmodule

// ===== hw/flash_call_pkg.sv
// Types shared by the supervisory flash call engine
package flash_call_pkg;
	// Engine sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_CHECK = 4'h1,
		ST_EA_USER = 4'h2,
		ST_EA_PROT = 4'h3,
		ST_TABLE = 4'h4,
		ST_CSUM = 4'h5,
		ST_CSUM_END = 4'h6,
		ST_FINISH = 4'h7
	} engine_state_e;

	// Commands towards the flash macro
	typedef enum logic [2:0] {
		FL_NONE = 3'h0,
		FL_ERASE_USER = 3'h1,
		FL_PROG_ZERO = 3'h2,
		FL_ERASE_PROT = 3'h3,
		FL_PROG_PROT_ZERO = 3'h4,
		FL_READ = 3'h5,
		FL_TABLE_READ = 3'h6
	} flash_op_e;
endpackage

// ===== hw/flash_cmd_port.sv
// Request and acknowledge port towards one flash macro
`timescale 1ns/1ps
module flash_cmd_port
	import flash_call_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Engine side
	input wire logic start,
	input wire flash_op_e op,
	input wire logic [1:0] macro,
	input wire logic [13:0] addr,
	output logic done,
	output logic [7:0] rdata,
	// Flash side
	output logic fl_req,
	output flash_op_e fl_op,
	output logic [1:0] fl_macro,
	output logic [13:0] fl_addr,
	input wire logic fl_ack,
	input wire logic [7:0] fl_rdata
);
	logic req_reg, req_next; // Request held until acknowledge
	flash_op_e op_reg, op_next;
	logic [1:0] macro_reg, macro_next;
	logic [13:0] addr_reg, addr_next;
	logic done_reg, done_next; // One-cycle completion pulse
	logic [7:0] rdata_reg, rdata_next;

	// Hold command steady while pending; the flash paces the step
	always_comb begin
		req_next = req_reg;
		op_next = op_reg;
		macro_next = macro_reg;
		addr_next = addr_reg;
		done_next = 1'b0;
		rdata_next = rdata_reg;
		if (req_reg) begin
			if (fl_ack) begin
				req_next = 1'b0;
				done_next = 1'b1;
				rdata_next = fl_rdata;
			end
		end else if (start) begin
			req_next = 1'b1;
			op_next = op;
			macro_next = macro;
			addr_next = addr;
		end
	end

	// Register only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_reg <= 1'b0;
			op_reg <= FL_NONE;
			macro_reg <= 2'h0;
			addr_reg <= 14'h0000;
			done_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			req_reg <= req_next;
			op_reg <= op_next;
			macro_reg <= macro_next;
			addr_reg <= addr_next;
			done_reg <= done_next;
			rdata_reg <= rdata_next;
		end
	end

	assign fl_req = req_reg;
	assign fl_op = op_reg;
	assign fl_macro = macro_reg;
	assign fl_addr = addr_reg;
	assign done = done_reg;
	assign rdata = rdata_reg;
endmodule

// ===== hw/sum16_acc.sv
// Sixteen-bit additive checksum accumulator
`timescale 1ns/1ps
module sum16_acc (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic clr,
	input wire logic add,
	input wire logic [7:0] data,
	// Result
	output logic [15:0] sum
);
	logic [15:0] sum_reg; // Running sum
	logic [15:0] sum_next;

	// Low byte adds the data, its carry ripples into the high byte
	always_comb begin
		sum_next = sum_reg;
		if (clr) begin
			sum_next = 16'h0000;
		end else if (add) begin
			sum_next = sum_reg + {8'h00, data};
		end
	end

	// Register only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum_reg <= 16'h0000;
		end else begin
			sum_reg <= sum_next;
		end
	end

	assign sum = sum_reg;
endmodule
